/* File: kwd_watchdog.v */
// Keyed watchdog / interval timer with word-keyed register writes
//
// How it works
// - Pin reset loads reset register; overflow reset doesn't
// - Watchdog flag set on wrap, watchdog mode only
// - Watchdog flag clears after read-then-write-zero
// - Overflow with enable resets chip; timer reinit always
// - Type bit: 0 power-on, 1 manual reset
// - Reset register low five bits read one
// - Counter/control written only by word writes
// - Shared address; key 5A counter, A5 control
// - Reset register word-written at FFBE only
// - Key A5 data 00 clears watchdog flag
// - Key 5A copies bits 6,5 to enable/type
// - Byte reads at FFBC, FFBD, FFBF
// - Overflow output low 132 or 130 states
// - Chip reset with output, held 518 states
// - Pin reset beats overflow; flag ends cleared
// - Interval overflow sets flag and interrupt request
// - Watchdog flag sets as overflow output falls
// - Write wins over coinciding count pulse
// - Eight-bit up-counter runs on prescaler pulses
// - Select picks one of eight clock divisors
// - Run enable low holds counter at zero
// - Mode bit: 0 interval, 1 watchdog
`timescale 1ns/1ps
`include "kwd_regs.vh"
module kwd_watchdog #(
	parameter DIV_W = `KWD_DIV_W
) (
	// Clock and reset; srst is the synchronised external reset pin
	input wire sys_clk,
	input wire srst,
	// Register bus
	input wire [15:0] bus_addr,
	input wire bus_wr,
	input wire bus_rd,
	input wire bus_word,
	input wire [15:0] bus_wdata,
	output reg [7:0] bus_rdata,
	// Watchdog outputs
	output wire overflow_out_n,
	output wire chip_reset_por,
	output wire chip_reset_manual,
	// Interval interrupt
	output wire interval_timer_irq
);
	localparam PW = 10;
	localparam [PW-1:0] LEN_OVF_RST = `KWD_OVF_STATES_RST;
	localparam [PW-1:0] LEN_OVF_NORST = `KWD_OVF_STATES_NORST;
	localparam [PW-1:0] LEN_CHIPRST = `KWD_CHIPRST_STATES;

	reg [7:0] count_reg;
	reg interval_overflow_flag_reg;
	reg timer_mode_select_reg;
	reg count_run_enable_reg;
	reg [2:0] prescaler_select_reg;
	reg watchdog_overflow_flag_reg;
	reg chip_reset_enable_reg;
	reg reset_type_select_reg;
	reg wflag_seen_reg;
	reg iflag_seen_reg;
	reg reset_type_latched_reg;

	wire tick;
	wire ovf_active;
	wire rst_active;
	wire wrap;
	wire wd_ovf;
	wire it_ovf;
	wire word_wr;
	wire key_cnt_wr;
	wire key_tcs_wr;
	wire key_flag_clr;
	wire key_rcs_ctrl;
	wire [7:0] wlo;
	wire [7:0] whi;
	wire [7:0] tcs_view;
	wire [7:0] rcs_view;

	kwd_prescaler #(
		.DIV_W(DIV_W)
	) u_pre (
		.sys_clk(sys_clk),
		.srst(srst),
		.run(count_run_enable_reg),
		.sel(prescaler_select_reg),
		.tick(tick)
	);

	assign wlo = bus_wdata[7:0];
	assign whi = bus_wdata[15:8];
	// Writes are locked out while the overflow output is low
	assign word_wr = bus_wr & bus_word & ~ovf_active;
	assign key_cnt_wr = word_wr && bus_addr == `KWD_ADDR_TCS && whi == `KWD_KEY_CNT;
	assign key_tcs_wr = word_wr && bus_addr == `KWD_ADDR_TCS && whi == `KWD_KEY_TCS;
	assign key_flag_clr = word_wr && bus_addr == `KWD_ADDR_RCS_WR &&
		whi == `KWD_KEY_RCS_FLAG && wlo == `KWD_FLAG_CLR_DATA;
	assign key_rcs_ctrl = word_wr && bus_addr == `KWD_ADDR_RCS_WR &&
		whi == `KWD_KEY_RCS_CTRL;
	// Any other key falls through all four decodes and changes nothing

	assign wrap = count_run_enable_reg & tick & ~key_cnt_wr &
		(count_reg == `KWD_CNT_MAX);
	assign wd_ovf = wrap & timer_mode_select_reg;
	assign it_ovf = wrap & ~timer_mode_select_reg;

	kwd_pulse_timer #(
		.W(PW)
	) u_ovf (
		.sys_clk(sys_clk),
		.srst(srst),
		.start(wd_ovf),
		.len(chip_reset_enable_reg ? LEN_OVF_RST : LEN_OVF_NORST),
		.active(ovf_active)
	);

	kwd_pulse_timer #(
		.W(PW)
	) u_rst (
		.sys_clk(sys_clk),
		.srst(srst),
		.start(wd_ovf & chip_reset_enable_reg),
		.len(LEN_CHIPRST),
		.active(rst_active)
	);

	assign overflow_out_n = ~ovf_active;
	assign chip_reset_por = rst_active & ~reset_type_latched_reg;
	assign chip_reset_manual = rst_active & reset_type_latched_reg;
	assign interval_timer_irq = interval_overflow_flag_reg;

	// Flag, mode and run sit above the two always-one bits and the select
	assign tcs_view = {interval_overflow_flag_reg, timer_mode_select_reg,
		count_run_enable_reg, 2'b00, prescaler_select_reg} | `KWD_TCS_RSVD;
	assign rcs_view = {watchdog_overflow_flag_reg, chip_reset_enable_reg,
		reset_type_select_reg, 5'h00} | `KWD_RCS_RSVD;

	// Counter and timer control; reinitialised by a watchdog overflow
	always @(posedge sys_clk) begin
		if (srst || wd_ovf) begin
			count_reg <= `KWD_CNT_RESET;
			timer_mode_select_reg <= 1'b0;
			count_run_enable_reg <= 1'b0;
			prescaler_select_reg <= 3'h0;
		end else begin
			if (key_tcs_wr) begin
				timer_mode_select_reg <= wlo[`KWD_TCS_MODE];
				count_run_enable_reg <= wlo[`KWD_TCS_RUN];
				prescaler_select_reg <= wlo[`KWD_TCS_PS_HI:`KWD_TCS_PS_LO];
			end
			if (!count_run_enable_reg || (key_tcs_wr && !wlo[`KWD_TCS_RUN]))
				count_reg <= `KWD_CNT_RESET;
			else if (key_cnt_wr)
				count_reg <= wlo;
			else if (tick)
				count_reg <= count_reg + 8'h01;
		end
	end

	// Interval flag: set wins over clear; clear needs prior read of it set
	always @(posedge sys_clk) begin
		if (srst) begin
			interval_overflow_flag_reg <= 1'b0;
			iflag_seen_reg <= 1'b0;
		end else begin
			if (bus_rd && bus_addr == `KWD_ADDR_TCS && interval_overflow_flag_reg)
				iflag_seen_reg <= 1'b1;
			if (it_ovf)
				interval_overflow_flag_reg <= 1'b1;
			else if (key_tcs_wr && iflag_seen_reg && !wlo[`KWD_TCS_FLAG]) begin
				interval_overflow_flag_reg <= 1'b0;
				iflag_seen_reg <= 1'b0;
			end
		end
	end

	// Reset control: only the pin reset initialises it
	always @(posedge sys_clk) begin
		if (srst) begin
			watchdog_overflow_flag_reg <= 1'b0;
			chip_reset_enable_reg <= 1'b0;
			reset_type_select_reg <= 1'b0;
			wflag_seen_reg <= 1'b0;
			reset_type_latched_reg <= 1'b0;
		end else begin
			// Reads during the low output are not recognised
			if (bus_rd && !ovf_active && bus_addr == `KWD_ADDR_TCS &&
				watchdog_overflow_flag_reg)
				wflag_seen_reg <= 1'b1;
			if (wd_ovf) begin
				watchdog_overflow_flag_reg <= 1'b1;
				reset_type_latched_reg <= reset_type_select_reg;
			end else if (key_flag_clr && wflag_seen_reg) begin
				watchdog_overflow_flag_reg <= 1'b0;
				wflag_seen_reg <= 1'b0;
			end
			if (key_rcs_ctrl) begin
				chip_reset_enable_reg <= wlo[`KWD_RCS_ENA];
				reset_type_select_reg <= wlo[`KWD_RCS_TYPE];
			end
		end
	end

	// Registered byte read data
	always @(posedge sys_clk) begin
		if (srst)
			bus_rdata <= 8'h00;
		else if (bus_rd) begin
			case (bus_addr)
				`KWD_ADDR_TCS: bus_rdata <= tcs_view;
				`KWD_ADDR_CNT_RD: bus_rdata <= count_reg;
				`KWD_ADDR_RCS_RD: bus_rdata <= rcs_view;
				default: bus_rdata <= 8'h00;
			endcase
		end
	end
endmodule

/* File: kwd_regs.vh */
// Register addresses, keys, field positions, reset values and timing counts
`ifndef KWD_REGS_VH
`define KWD_REGS_VH

`define KWD_ADDR_TCS 16'hffbc
`define KWD_ADDR_CNT_RD 16'hffbd
`define KWD_ADDR_RCS_WR 16'hffbe
`define KWD_ADDR_RCS_RD 16'hffbf

`define KWD_KEY_CNT 8'h5a
`define KWD_KEY_TCS 8'ha5
`define KWD_KEY_RCS_FLAG 8'ha5
`define KWD_KEY_RCS_CTRL 8'h5a
`define KWD_FLAG_CLR_DATA 8'h00

`define KWD_TCS_FLAG 7
`define KWD_TCS_MODE 6
`define KWD_TCS_RUN 5
`define KWD_TCS_PS_HI 2
`define KWD_TCS_PS_LO 0
`define KWD_TCS_RSVD 8'h18
`define KWD_TCS_RESET 8'h18

`define KWD_RCS_FLAG 7
`define KWD_RCS_ENA 6
`define KWD_RCS_TYPE 5
`define KWD_RCS_RSVD 8'h1f
`define KWD_RCS_RESET 8'h1f

`define KWD_CNT_RESET 8'h00
`define KWD_CNT_MAX 8'hff

`define KWD_OVF_STATES_RST 132
`define KWD_OVF_STATES_NORST 130
`define KWD_CHIPRST_STATES 518

`define KWD_DIV_W 17

`endif

/* File: kwd_prescaler.v */
// Prescaler, cleared while run is low, producing one-cycle count pulses at the selected tap
`timescale 1ns/1ps
`include "kwd_regs.vh"
module kwd_prescaler #(
	parameter DIV_W = `KWD_DIV_W
) (
	// Clock and reset
	input wire sys_clk,
	input wire srst,
	// Control
	input wire run,
	input wire [2:0] sel,
	// Count pulse
	output reg tick
);
	reg [DIV_W-1:0] div_reg;
	reg [DIV_W-1:0] prev_reg;
	reg [4:0] tap;

	// Divide ratios 2,64,128,512,2048,8192,32768,131072 as bit positions
	always @* begin
		case (sel)
			3'h0: tap = 5'h00;
			3'h1: tap = 5'h05;
			3'h2: tap = 5'h06;
			3'h3: tap = 5'h08;
			3'h4: tap = 5'h0a;
			3'h5: tap = 5'h0c;
			3'h6: tap = 5'h0e;
			default: tap = 5'h10;
		endcase
	end

	always @(posedge sys_clk) begin
		if (srst || !run) begin
			div_reg <= {DIV_W{1'b0}};
			prev_reg <= {DIV_W{1'b0}};
			tick <= 1'b0;
		end else begin
			div_reg <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
			prev_reg <= div_reg;
			// Falling edge of the tap bit: one pulse per full period
			tick <= prev_reg[tap] & ~div_reg[tap];
		end
	end
endmodule

/* File: kwd_pulse_timer.v */
// Down-counter that holds an active output for a loaded number of cycles
`timescale 1ns/1ps
module kwd_pulse_timer #(
	parameter W = 10
) (
	// Clock and reset
	input wire sys_clk,
	input wire srst,
	// Start with length
	input wire start,
	input wire [W-1:0] len,
	// Level while running
	output wire active
);
	reg [W-1:0] cnt_reg;

	always @(posedge sys_clk) begin
		if (srst)
			cnt_reg <= {W{1'b0}};
		else if (start)
			cnt_reg <= len;
		else if (cnt_reg != {W{1'b0}})
			cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
	end

	assign active = (cnt_reg != {W{1'b0}});
endmodule

/* File: kwd_watchdog_sva.sv */
// Checker for overflow pulse, chip reset and read-back timing
`timescale 1ns/1ps
module kwd_watchdog_sva (
	// Clock and reset
	input wire sys_clk,
	input wire srst,
	// Register bus
	input wire [15:0] bus_addr,
	input wire bus_wr,
	input wire bus_rd,
	input wire bus_word,
	input wire [15:0] bus_wdata,
	input wire [7:0] bus_rdata,
	// Outputs
	input wire overflow_out_n,
	input wire chip_reset_por,
	input wire chip_reset_manual,
	input wire interval_timer_irq
);
	wire crst = chip_reset_por | chip_reset_manual;
	reg [9:0] low_reg;
	reg [9:0] rst_reg;
	reg ena_reg;
	// Lengths counted here, since repetition counts cannot reach 132
	always @(posedge sys_clk) begin
		if (srst) begin
			low_reg <= 10'h0;
			rst_reg <= 10'h0;
			ena_reg <= 1'b0;
		end else begin
			low_reg <= overflow_out_n ? 10'h0 : low_reg + 10'h1;
			rst_reg <= crst ? rst_reg + 10'h1 : 10'h0;
			if (!overflow_out_n && low_reg == 10'h0)
				ena_reg <= crst;
		end
	end
	a_ovf_low_len: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(overflow_out_n) && !$past(srst) |-> low_reg == (ena_reg ? 10'h084 : 10'h082))
		else $error("overflow pulse length wrong");
	a_crst_len: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(crst) && !$past(srst) |-> rst_reg == 10'h206) else $error("chip reset length wrong");
	a_crst_with_ovf: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(crst) |-> $fell(overflow_out_n)) else $error("chip reset not with overflow");
	a_type_excl: assert property (@(posedge sys_clk) disable iff (srst)
		!(chip_reset_por && chip_reset_manual)) else $error("both reset types asserted");
	a_pin_reset_quiet: assert property (@(posedge sys_clk)
		srst |=> overflow_out_n && !crst && !interval_timer_irq) else $error("outputs not reset");
	a_ovf_not_irq: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(overflow_out_n) |-> !$rose(interval_timer_irq)) else $error("irq in watchdog mode");
	a_rcs_ones: assert property (@(posedge sys_clk) disable iff (srst)
		bus_rd && bus_addr == 16'hffbf |=> bus_rdata[4:0] == 5'h1f) else $error("low bits not one");
	a_rdata_hold: assert property (@(posedge sys_clk) disable iff (srst)
		!bus_rd |=> $stable(bus_rdata)) else $error("read data changed without read");
	a_irq_clear_wr: assert property (@(posedge sys_clk) disable iff (srst)
		$fell(interval_timer_irq) && !$past(srst) |-> ($past(bus_wr) && $past(bus_word))
		|| !overflow_out_n) else $error("irq cleared without write");
endmodule
bind kwd_watchdog kwd_watchdog_sva chk (.sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_word(bus_word), .bus_wdata(bus_wdata),
	.bus_rdata(bus_rdata), .overflow_out_n(overflow_out_n), .chip_reset_por(chip_reset_por),
	.chip_reset_manual(chip_reset_manual), .interval_timer_irq(interval_timer_irq));

/* File: test_keyed_watchdog_interval_timer.sv */
// Register-level test sequence for the keyed watchdog timer
`timescale 1ns/1ps
module test_keyed_watchdog_interval_timer;
	reg sys_clk = 1'b0;
	reg srst = 1'b1;
	reg [15:0] bus_addr = 16'h0;
	reg [15:0] bus_wdata = 16'h0;
	reg bus_wr = 1'b0, bus_rd = 1'b0, bus_word = 1'b0;
	wire [7:0] bus_rdata;
	wire overflow_out_n, chip_reset_por, chip_reset_manual, interval_timer_irq;
	integer err_count = 0, n_checks = 0, cyc = 0, i, n;
	reg [7:0] c;
	always #2 sys_clk = ~sys_clk;
	kwd_watchdog dut (.sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.overflow_out_n(overflow_out_n), .chip_reset_por(chip_reset_por),
		.chip_reset_manual(chip_reset_manual), .interval_timer_irq(interval_timer_irq));
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", n_checks, err_count);
			if (err_count == 0 && n_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [15:0] a, input [15:0] d, input w);
		begin
			@(posedge sys_clk);
			bus_addr <= a;
			bus_wdata <= d;
			bus_word <= w;
			bus_wr <= 1'b1;
			@(posedge sys_clk);
			bus_wr <= 1'b0;
		end
	endtask
	task rd(input [15:0] a, input [7:0] exp);
		begin
			@(posedge sys_clk);
			bus_addr <= a;
			bus_rd <= 1'b1;
			@(posedge sys_clk);
			bus_rd <= 1'b0;
			@(negedge sys_clk);
			chk(bus_rdata, exp);
		end
	endtask
	task wait_ovf(input lvl);
		begin
			n = 0;
			while (overflow_out_n !== lvl && n < 1000) begin
				@(negedge sys_clk);
				n = n + 1;
			end
			chk({7'h0, overflow_out_n}, {7'h0, lvl});
		end
	endtask
	// Hang guard well above the three overflow runs
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			give_verdict;
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		rd(16'hffbc, 8'h18);
		rd(16'hffbd, 8'h00);
		rd(16'hffbf, 8'h1f);
		wr(16'hffbc, 16'h5a33, 1'b0);
		wr(16'hffbc, 16'h1233, 1'b1);
		wr(16'hffbe, 16'h5a60, 1'b0);
		rd(16'hffbd, 8'h00);
		rd(16'hffbc, 8'h18);
		rd(16'hffbf, 8'h1f);
		$display("test access done");
		wr(16'hffbc, 16'ha520, 1'b1);
		wr(16'hffbc, 16'h5afd, 1'b1);
		i = 0;
		while (interval_timer_irq !== 1'b1 && i < 100) begin
			@(negedge sys_clk);
			i = i + 1;
		end
		chk({7'h0, interval_timer_irq}, 8'h01);
		rd(16'hffbc, 8'hb8);
		rd(16'hffbf, 8'h1f);
		wr(16'hffbc, 16'ha518, 1'b1);
		rd(16'hffbc, 8'h18);
		rd(16'hffbd, 8'h00);
		chk({7'h0, interval_timer_irq}, 8'h00);
		$display("test interval done");
		for (i = 0; i < 3; i = i + 1) begin
			c = (i == 0) ? 8'h60 : (i == 1) ? 8'h40 : 8'h00;
			wr(16'hffbe, {8'h5a, c}, 1'b1);
			rd(16'hffbf, c | 8'h1f);
			wr(16'hffbc, 16'ha540, 1'b1);
			wr(16'hffbc, 16'ha560, 1'b1);
			wr(16'hffbc, 16'h5afe, 1'b1);
			wait_ovf(1'b0);
			chk({6'h0, chip_reset_por, chip_reset_manual},
				{6'h0, c[6] & ~c[5], c[6] & c[5]});
			wait_ovf(1'b1);
			rd(16'hffbf, c | 8'h9f);
			rd(16'hffbc, 8'h18);
			wr(16'hffbe, 16'ha500, 1'b1);
			rd(16'hffbf, c | 8'h1f);
			n = 0;
			while ((chip_reset_por | chip_reset_manual) !== 1'b0 && n < 600) begin
				@(negedge sys_clk);
				n = n + 1;
			end
			$display("test watchdog %0d done", i);
		end
		wr(16'hffbe, 16'h5a60, 1'b1);
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		rd(16'hffbf, 8'h1f);
		$display("test pin reset done");
		give_verdict;
	end
endmodule
